/* File: common/slcd_regs.vh */
// Purpose: register offsets, field positions and reset values of the segment display controller
// Assumes: word-indexed plain register port
// Notes: included by the controller and its testbench
`ifndef SLCD_REGS_VH
`define SLCD_REGS_VH
`define SLCD_ADDR_W 6
`define SLCD_OFF_CTRL 6'h00
`define SLCD_OFF_FRAME 6'h01
`define SLCD_OFF_STATUS 6'h02
`define SLCD_OFF_CLR 6'h03
`define SLCD_OFF_IEN 6'h04
`define SLCD_OFF_BLINK 6'h05
`define SLCD_OFF_RAM 6'h10
`define SLCD_CTRL_EN 0
`define SLCD_CTRL_EXTSRC 1
`define SLCD_CTRL_DUTY_LO 2
`define SLCD_CTRL_BIAS_LO 5
`define SLCD_CTRL_HIDRV 7
`define SLCD_CTRL_CONTR_LO 8
`define SLCD_CTRL_UPD 11
`define SLCD_CTRL_RST 32'h0000_0000
`define SLCD_FRAME_RST 32'h0000_0010
`define SLCD_BLINK_RST 32'h0000_0000
`define SLCD_ST_SOF 0
`define SLCD_ST_UDD 1
`define SLCD_BMODE_OFF 3'h0
`define SLCD_BMODE_ALL 3'h6
`endif

/* File: src/slcd_common_slot.v */
// Purpose: one common line drive level with phase inversion
// Assumes: levels encoded 0..4 as fractions of panel voltage times bias steps
// Notes: instantiated once per common line
`timescale 1ns/1ns
module slcd_common_slot #(
  parameter IDX = 0
)
(
  input wire clk_in,
  input wire resetn_in,
  input wire [2:0] slot_in,
  input wire active_in,
  input wire inv_in,
  input wire [2:0] bias_max_in,
  output reg [2:0] level_out
);
  always @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      level_out <= 3'h0;
    else if (!active_in)
      level_out <= 3'h0;
    else if (slot_in == IDX[2:0])
      level_out <= inv_in ? 3'h0 : bias_max_in;
    else
      level_out <= inv_in ? (bias_max_in - 3'h1) : ((bias_max_in > 3'h1) ? 3'h1 : 3'h0);
  end
endmodule

/* File: src/slcd_ctrl.v */
// Purpose: segment display controller with double buffered pixel memory
// Assumes: one clock; register port with read data one cycle later
// Notes: levels are codes 0..bias steps for the analog buffers
// Summary of operation
// [R1] duty static, 1/2, 1/3, 1/4, 1/8
// [R2] bias static, 1/2, 1/3, 1/4
// [R3] pixel memory double buffered
// [R4] sixteen 32-bit pixel words
// [R5] frame rate from programmable clock division
// [R6] contrast setting driven to converter
// [R7] external source disables boost enable
// [R8] resistive network structure driven out
// [R9] dead time zero to eight phases
// [R10] runs in low power, software disable
// [R11] phase inversion removes dc
// [R12] start-of-frame event raises interrupt
// [R13] blink one, two, three, four, eight, all
// [R14] blink rate about 0.5 to 4 Hz
// [R15] each common gets its own slot
// [R16] copy at frame boundary, flag done
// [R17] flag sticky until cleared, gated interrupt
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ns
`include "slcd_regs.vh"
module slcd_ctrl #(
  parameter NCOM = 8,
  parameter NSEG = 32,
  parameter NWORD = 16
)
(
  input wire clk_in,
  input wire resetn_in,
  input wire [5:0] addr_in,
  input wire [31:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [31:0] rdata_out,
  output reg [NCOM*3-1:0] com_level_out,
  output reg [NSEG*3-1:0] seg_level_out,
  output reg boost_en_out,
  output reg ext_src_out,
  output reg hi_drive_out,
  output reg [2:0] contrast_out,
  output reg irq_out
);
  reg [31:0] ram_q [0:NWORD-1];
  reg [31:0] disp_q [0:NWORD-1];
  reg [31:0] ctrl_q;
  reg [31:0] frame_q;
  reg [31:0] blink_q;
  reg [1:0] stat_q;
  reg [1:0] ien_q;
  reg upd_req_q;
  reg [15:0] div_q;
  reg [2:0] slot_q;
  reg inv_q;
  reg [3:0] dead_q;
  reg [7:0] blink_cnt_q;
  reg blink_ph_q;
  reg sof_q;
  wire [NCOM*3-1:0] com_lv;
  reg [NSEG*3-1:0] seg_stage_q;
  integer i;
  integer j;
  wire en = ctrl_q[`SLCD_CTRL_EN];
  wire [2:0] duty = ctrl_q[`SLCD_CTRL_DUTY_LO+2:`SLCD_CTRL_DUTY_LO];
  wire [1:0] bias = ctrl_q[`SLCD_CTRL_BIAS_LO+1:`SLCD_CTRL_BIAS_LO];
  wire [15:0] div_max = frame_q[15:0];
  wire [3:0] dead_max = frame_q[19:16];
  wire [2:0] bmode = blink_q[2:0];
  wire [1:0] brate = blink_q[5:4];
  reg [2:0] last_slot;
  reg [2:0] bias_max;
  reg [7:0] brate_max;
  // duty code to last common slot
  always @*
  begin
    case (duty) // [R1]
      3'h0: last_slot = 3'h0;
      3'h1: last_slot = 3'h1;
      3'h2: last_slot = 3'h2;
      3'h3: last_slot = 3'h3;
      default: last_slot = 3'h7;
    endcase
    case (bias) // [R2]
      2'h0: bias_max = 3'h1;
      2'h1: bias_max = 3'h2;
      2'h2: bias_max = 3'h3;
      default: bias_max = 3'h4;
    endcase
    case (brate) // [R14]
      2'h0: brate_max = 8'h0f;
      2'h1: brate_max = 8'h1f;
      2'h2: brate_max = 8'h3f;
      default: brate_max = 8'h7f;
    endcase
  end
  wire tick = en && (div_q == div_max); // [R5]
  wire in_dead = (dead_q != 4'h0);
  wire frame_end = tick && !in_dead && (slot_q == last_slot) && inv_q;
  wire dead_end = tick && (dead_q == 4'h1);
  wire frame_start = (frame_end && dead_max == 4'h0) || dead_end;
  // frame sequencer
  always @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      div_q <= 16'h0000;
      slot_q <= 3'h0;
      inv_q <= 1'b0;
      dead_q <= 4'h0;
      blink_cnt_q <= 8'h00;
      blink_ph_q <= 1'b0;
      sof_q <= 1'b0;
    end
    else
    begin
      sof_q <= frame_start;
      if (!en) // [R10]
      begin
        div_q <= 16'h0000;
        slot_q <= 3'h0;
        inv_q <= 1'b0;
        dead_q <= 4'h0;
      end
      else if (tick)
      begin
        div_q <= 16'h0000;
        if (in_dead)
          dead_q <= dead_q - 4'h1; // [R9]
        else if (inv_q)
        begin
          inv_q <= 1'b0;
          if (slot_q == last_slot) // [R15]
          begin
            slot_q <= 3'h0;
            dead_q <= (dead_max > 4'h8) ? 4'h8 : dead_max; // [R9]
          end
          else
            slot_q <= slot_q + 3'h1;
        end
        else
          inv_q <= 1'b1; // [R11]
      end
      else
        div_q <= div_q + 16'h0001;
      if (frame_end)
      begin
        if (blink_cnt_q >= brate_max) // [R14]
        begin
          blink_cnt_q <= 8'h00;
          blink_ph_q <= ~blink_ph_q;
        end
        else
          blink_cnt_q <= blink_cnt_q + 8'h01;
      end
    end
  end
  genvar g;
  generate
    for (g = 0; g < NCOM; g = g + 1)
    begin : com_gen
      localparam integer GI = g;
      slcd_common_slot #(.IDX(g)) u_slot (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .slot_in(slot_q),
        .active_in(en && !in_dead && (GI[2:0] <= last_slot)),
        .inv_in(inv_q),
        .bias_max_in(bias_max),
        .level_out(com_lv[g*3+2:g*3])
      );
    end
  endgenerate
  // segment bit with blink masking
  function seg_on;
    input [31:0] word;
    input [4:0] s;
    begin
      seg_on = word[s];
      if (blink_ph_q && bmode != `SLCD_BMODE_OFF) // [R13]
      begin
        case (bmode)
          3'h1: if (s == 5'd0) seg_on = 1'b0;
          3'h2: if (s < 5'd2) seg_on = 1'b0;
          3'h3: if (s < 5'd3) seg_on = 1'b0;
          3'h4: if (s < 5'd4) seg_on = 1'b0;
          3'h5: if (s < 5'd8) seg_on = 1'b0;
          default: seg_on = 1'b0;
        endcase
      end
    end
  endfunction
  wire [31:0] cur_word = disp_q[{1'b0, slot_q}];
  // segments take one extra stage to line up with the common slot outputs
  always @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      com_level_out <= {NCOM*3{1'b0}};
      seg_stage_q <= {NSEG*3{1'b0}};
      seg_level_out <= {NSEG*3{1'b0}};
      boost_en_out <= 1'b0;
      ext_src_out <= 1'b0;
      hi_drive_out <= 1'b0;
      contrast_out <= 3'h0;
      irq_out <= 1'b0;
    end
    else
    begin
      com_level_out <= com_lv;
      seg_level_out <= seg_stage_q; // [R15]
      // off segments mirror around the middle level when inverted
      for (i = 0; i < NSEG; i = i + 1)
      begin
        if (!en || in_dead) // [R9]
          seg_stage_q[i*3+:3] <= 3'h0;
        else if (seg_on(cur_word, i[4:0])) // [R15]
          seg_stage_q[i*3+:3] <= inv_q ? bias_max : 3'h0; // [R11]
        else if (bias_max > 3'h1)
          seg_stage_q[i*3+:3] <= inv_q ? (bias_max - 3'h2) : 3'h2; // [R11]
        else
          seg_stage_q[i*3+:3] <= inv_q ? 3'h0 : 3'h1;
      end
      ext_src_out <= ctrl_q[`SLCD_CTRL_EXTSRC]; // [R7]
      boost_en_out <= en && !ctrl_q[`SLCD_CTRL_EXTSRC]; // [R7]
      hi_drive_out <= ctrl_q[`SLCD_CTRL_HIDRV]; // [R8]
      contrast_out <= ctrl_q[`SLCD_CTRL_CONTR_LO+2:`SLCD_CTRL_CONTR_LO]; // [R6]
      irq_out <= |(stat_q & ien_q); // [R17]
    end
  end
  // register port and buffers
  always @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      ctrl_q <= `SLCD_CTRL_RST;
      frame_q <= `SLCD_FRAME_RST;
      blink_q <= `SLCD_BLINK_RST;
      stat_q <= 2'h0;
      ien_q <= 2'h0;
      upd_req_q <= 1'b0;
      rdata_out <= 32'h0000_0000;
      for (j = 0; j < NWORD; j = j + 1)
      begin
        ram_q[j] <= 32'h0000_0000;
        disp_q[j] <= 32'h0000_0000;
      end
    end
    else
    begin
      if (wr_in && addr_in == `SLCD_OFF_CLR)
        stat_q <= stat_q & ~wdata_in[1:0];
      // a set in the same cycle as a clear wins
      if (sof_q)
        stat_q[`SLCD_ST_SOF] <= 1'b1; // [R12]
      if (frame_start && upd_req_q) // [R16]
      begin
        for (j = 0; j < NWORD; j = j + 1)
          disp_q[j] <= ram_q[j]; // [R3]
        stat_q[`SLCD_ST_UDD] <= 1'b1; // [R16]
        upd_req_q <= 1'b0;
      end
      if (wr_in)
      begin
        if (addr_in == `SLCD_OFF_CTRL)
        begin
          ctrl_q <= wdata_in & 32'h0000_07ff;
          if (wdata_in[`SLCD_CTRL_UPD])
            upd_req_q <= 1'b1; // [R16]
        end
        if (addr_in == `SLCD_OFF_FRAME)
          frame_q <= wdata_in & 32'h000f_ffff;
        if (addr_in == `SLCD_OFF_BLINK)
          blink_q <= wdata_in & 32'h0000_0037;
        if (addr_in == `SLCD_OFF_IEN)
          ien_q <= wdata_in[1:0];
        if (addr_in[5:4] == 2'h1)
          ram_q[addr_in[3:0]] <= wdata_in; // [R4]
      end
      if (rd_in)
      begin
        if (addr_in == `SLCD_OFF_CTRL)
          rdata_out <= {20'h00000, upd_req_q, ctrl_q[10:0]};
        else if (addr_in == `SLCD_OFF_FRAME)
          rdata_out <= frame_q;
        else if (addr_in == `SLCD_OFF_STATUS)
          rdata_out <= {30'h0, stat_q};
        else if (addr_in == `SLCD_OFF_IEN)
          rdata_out <= {30'h0, ien_q};
        else if (addr_in == `SLCD_OFF_BLINK)
          rdata_out <= blink_q;
        else if (addr_in[5:4] == 2'h1)
          rdata_out <= ram_q[addr_in[3:0]];
        else
          rdata_out <= 32'h0000_0000;
      end
      else
        rdata_out <= 32'h0000_0000;
    end
  end
endmodule

/* File: verif/slcd_ctrl_chk.sv */
// Purpose: port checks for the segment display controller
// Assumes: register writes reach outputs within three edges
// Notes: bound to every slcd_ctrl
`timescale 1ns/1ns
module slcd_ctrl_chk #(
  parameter NCOM = 8
)
(
  input wire clk_in,
  input wire resetn_in,
  input wire [5:0] addr_in,
  input wire [31:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  input wire [31:0] rdata_out,
  input wire [NCOM*3-1:0] com_level_out,
  input wire boost_en_out,
  input wire ext_src_out,
  input wire hi_drive_out,
  input wire [2:0] contrast_out,
  input wire irq_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);
  sequence ctrl_wr;
    wr_in && addr_in == 6'h00;
  endsequence
  sequence ien_off;
    wr_in && addr_in == 6'h04 && wdata_in == 32'h0;
  endsequence
  boost_wr_a: assert property (ctrl_wr |-> ##3
    boost_en_out == ($past(wdata_in[0], 3) && !$past(wdata_in[1], 3))) else $error("boost");
  ext_wr_a: assert property (ctrl_wr |-> ##3 ext_src_out == $past(wdata_in[1], 3))
    else $error("source select");
  ext_boost_a: assert property (ext_src_out |-> !boost_en_out) else $error("boost on ext");
  contrast_wr_a: assert property (ctrl_wr |-> ##3
    contrast_out == $past(wdata_in[10:8], 3)) else $error("contrast");
  hidrive_wr_a: assert property (ctrl_wr |-> ##3
    hi_drive_out == $past(wdata_in[7], 3)) else $error("network drive");
  irq_mask_a: assert property (ien_off |-> ##3 !irq_out) else $error("irq masked");
  unmapped_rd_a: assert property (rd_in && addr_in >= 6'h20 |=> rdata_out == 32'h0)
    else $error("unmapped read");
  level_range_a: assert property (com_level_out[2:0] <= 3'h4) else $error("level");
endmodule
bind slcd_ctrl slcd_ctrl_chk #(.NCOM(NCOM)) u_chk (.clk_in(clk_in), .resetn_in(resetn_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .com_level_out(com_level_out), .boost_en_out(boost_en_out),
  .ext_src_out(ext_src_out), .hi_drive_out(hi_drive_out), .contrast_out(contrast_out),
  .irq_out(irq_out));

/* File: verif/slcd_panel_model.sv */
// Purpose: passive panel stand-in counting driven cycles
// Assumes: level code 0 leaves a common undriven
// Notes: also counts codes beyond the quarter bias range
`timescale 1ns/1ns
module slcd_panel_model #(
  parameter NCOM = 8
)
(
  input wire clk_in,
  input wire [NCOM*3-1:0] com_level_in,
  output wire [31:0] drive_cnt_out,
  output wire [31:0] over_cnt_out
);
  integer i;
  reg [31:0] drive_q = 32'h0000_0000;
  reg [31:0] over_q = 32'h0000_0000;
  assign drive_cnt_out = drive_q;
  assign over_cnt_out = over_q;
  always @(posedge clk_in)
  begin
    if (|com_level_in)
      drive_q <= drive_q + 32'h0000_0001;
    for (i = 0; i < NCOM; i = i + 1)
      if (com_level_in[i*3+:3] > 3'h4)
        over_q <= over_q + 32'h0000_0001;
  end
endmodule

/* File: verif/tb.sv */
// Purpose: register level test of the segment display controller
// Assumes: hand-over register map and timing
// Notes: frame divider set to 2 for short frames
`timescale 1ns/1ns
`include "slcd_regs.vh"
module tb;
  `define CHK(g, e) begin n_compared = n_compared + 1; if ((g) !== (e)) begin \
    bad_count = bad_count + 1; $display("unexpected t=%0t got=%h exp=%h", $time, g, e); end end
  reg clk_in = 1'b0;
  reg resetn_in = 1'b0;
  reg [5:0] addr_in = 6'h00;
  reg [31:0] wdata_in = 32'h0;
  reg wr_in = 1'b0;
  reg rd_in = 1'b0;
  wire [31:0] rdata_out;
  wire [23:0] com_level_out;
  wire [95:0] seg_level_out;
  wire boost_en_out, ext_src_out, hi_drive_out, irq_out;
  wire [2:0] contrast_out;
  wire [31:0] drv;
  wire [31:0] over;
  integer i, n, c0;
  integer bad_count = 0;
  integer n_compared = 0;
  reg [31:0] rv = 32'h0;
  slcd_ctrl #(.NCOM(8), .NSEG(32), .NWORD(16)) DUT (.clk_in(clk_in), .resetn_in(resetn_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .com_level_out(com_level_out), .seg_level_out(seg_level_out),
    .boost_en_out(boost_en_out), .ext_src_out(ext_src_out), .hi_drive_out(hi_drive_out),
    .contrast_out(contrast_out), .irq_out(irq_out));
  slcd_panel_model #(.NCOM(8)) u_panel (.clk_in(clk_in), .com_level_in(com_level_out),
    .drive_cnt_out(drv), .over_cnt_out(over));
  always #20 clk_in = ~clk_in;
  task conclude;
  begin
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask
  task wr(input [5:0] a, input [31:0] d);
  begin
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  end
  endtask
  task rd(input [5:0] a);
  begin
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 rv = rdata_out;
  end
  endtask
  // waits for common k in its non-inverted selected phase
  task wait_com(input integer k);
  begin
    n = 0;
    while (com_level_out[k*3+:3] !== 3'h1 && n < 200)
    begin
      @(posedge clk_in);
      #1 n = n + 1;
    end
    if (com_level_out[k*3+:3] !== 3'h1)
    begin
      bad_count = bad_count + 1;
      disable tb.tests;
    end
  end
  endtask
  initial
  begin
    repeat (6) @(posedge clk_in);
    resetn_in <= 1'b1;
    begin : tests
      rd(6'h00);
      `CHK(rv, `SLCD_CTRL_RST)
      rd(6'h01);
      `CHK(rv, `SLCD_FRAME_RST)
      rd(6'h05);
      `CHK(rv, `SLCD_BLINK_RST)
      rd(6'h20);
      `CHK(rv, 32'h0)
      for (i = 0; i < 5; i = i + 1)
      begin
        wr(6'h00, (i << 2) | ((i % 4) << 5));
        rd(6'h00);
        `CHK(rv, (i << 2) | ((i % 4) << 5))
      end
      for (i = 0; i < 8; i = i + 1)
      begin
        wr(6'h05, i | ((i % 4) << 4));
        rd(6'h05);
        `CHK(rv, i | ((i % 4) << 4))
      end
      wr(6'h01, 32'h0000_0002);
      wr(6'h04, 32'h0000_0001);
      wr(6'h00, 32'h0000_0591);
      repeat (3) @(posedge clk_in);
      #1 `CHK({boost_en_out, hi_drive_out, contrast_out}, 5'h1d)
      n = 0;
      while (irq_out !== 1'b1 && n < 300)
      begin
        @(posedge clk_in);
        #1 n = n + 1;
      end
      if (irq_out !== 1'b1)
      begin
        bad_count = bad_count + 1;
        disable tests;
      end
      `CHK(irq_out, 1'b1)
      rd(6'h02);
      `CHK(rv[0], 1'b1)
      wr(6'h03, 32'h0000_0001);
      repeat (3) @(posedge clk_in);
      #1 `CHK(irq_out, 1'b0)
      rd(6'h02);
      `CHK(rv[0], 1'b0)
      wr(6'h04, 32'h0000_0000);
      wr(6'h10, 32'hffff_ffff);
      wr(6'h00, 32'h0000_0d91);
      n = 0;
      rv = 32'h0;
      while (rv[1] !== 1'b1 && n < 200)
      begin
        rd(6'h02);
        n = n + 1;
      end
      if (rv[1] !== 1'b1)
      begin
        bad_count = bad_count + 1;
        disable tests;
      end
      `CHK(rv[1], 1'b1)
      rd(6'h00);
      `CHK(rv[11], 1'b0)
      wait_com(0);
      `CHK(seg_level_out[2:0], 3'h0)
      wait_com(1);
      `CHK(seg_level_out[2:0], 3'h1)
      wr(6'h05, 32'h0000_0001);
      n = 0;
      while (!(com_level_out[2:0] === 3'h1 && seg_level_out[2:0] === 3'h1) && n < 2000)
      begin
        @(posedge clk_in);
        #1 n = n + 1;
      end
      if (!(com_level_out[2:0] === 3'h1 && seg_level_out[2:0] === 3'h1))
      begin
        bad_count = bad_count + 1;
        disable tests;
      end
      `CHK(seg_level_out[5:3], 3'h0)
      `CHK(seg_level_out[26:24], 3'h0)
      `CHK(drv > 0, 1'b1)
      wr(6'h00, 32'h0000_0003);
      repeat (3) @(posedge clk_in);
      #1 `CHK({ext_src_out, boost_en_out}, 2'b10)
      wr(6'h00, 32'h0000_0000);
      repeat (100) @(posedge clk_in);
      c0 = drv;
      repeat (100) @(posedge clk_in);
      `CHK(drv, c0)
      `CHK(seg_level_out, 96'h0)
      `CHK(over, 0)
    end
    conclude;
  end
endmodule
